// File: logic/isc_pkg.sv
// Constants and types shared by the ISA capability register design
package isc_pkg;
  // Register and field geometry
  localparam int ISC_WIDTH = 64;
  localparam int ISC_EXT_W = 26;
  localparam int ISC_CODE_MSB = 63;
  localparam int ISC_CODE_LSB = 62;
  localparam int ISC_PAD_W = ISC_CODE_LSB - ISC_EXT_W;
  // Native width codes
  localparam logic [1:0] ISC_CODE_32 = 2'h1;
  localparam logic [1:0] ISC_CODE_64 = 2'h2;
  localparam logic [1:0] ISC_CODE_128 = 2'h3;
  localparam logic [1:0] ISC_NATIVE_WIDTH_CODE = ISC_CODE_64;
  // Extension bit positions, one per letter
  localparam int ISC_BIT_A = 0;
  localparam int ISC_BIT_B = 1;
  localparam int ISC_BIT_C = 2;
  localparam int ISC_BIT_D = 3;
  localparam int ISC_BIT_E = 4;
  localparam int ISC_BIT_F = 5;
  localparam int ISC_BIT_H = 7;
  localparam int ISC_BIT_I = 8;
  localparam int ISC_BIT_M = 12;
  localparam int ISC_BIT_Q = 16;
  localparam int ISC_BIT_S = 18;
  localparam int ISC_BIT_U = 20;
  localparam int ISC_BIT_V = 21;
  localparam int ISC_BIT_X = 23;
  // Extensions this hart carries: A B C D E F I M Q S U X
  localparam logic [25:0] ISC_EXT_SUPPORTED = 26'h095113F;
  // Extensions software may switch: A C D F I M
  localparam logic [25:0] ISC_EXT_WRITABLE = 26'h000112D;
  // Reset: everything supported, full integer base over embedded base
  localparam logic [25:0] ISC_EXT_RESET = 26'h095112F;
  // Write sequencing states
  typedef enum logic [1:0] {
    ISC_IDLE,
    ISC_CHECK,
    ISC_COMMIT
  } isc_state_t;
endpackage

// File: logic/isc_wr_if.sv
// Interface carrying a capability write between the controller and its helpers
`timescale 1ns/1ps
`default_nettype none
interface isc_wr_if;
  logic [25:0] cur_ext;
  logic [25:0] wr_ext;
  logic [25:0] legal_ext;
  logic next_addr_b1;
  logic suppress;
  // Controller side
  modport ctl (output cur_ext, output wr_ext, output next_addr_b1,
               input legal_ext, input suppress);
  // Legaliser side
  modport legal (input cur_ext, input wr_ext, output legal_ext);
  // Alignment checker side
  modport align (input cur_ext, input legal_ext, input next_addr_b1, output suppress);
endinterface
`default_nettype wire

// File: logic/isc_legalise.sv
// Turns any written extension value into a legal, supported one
`timescale 1ns/1ps
`default_nettype none
module isc_legalise (
  isc_wr_if.legal wr
);
  import isc_pkg::*;

  // Merge writable bits, mask to support, then apply dependencies
  always_comb begin
    logic [25:0] merged;
    merged = (wr.wr_ext & ISC_EXT_WRITABLE) | (wr.cur_ext & ~ISC_EXT_WRITABLE);
    merged = merged & ISC_EXT_SUPPORTED;
    if (!merged[ISC_BIT_F]) begin
      merged[ISC_BIT_D] = 1'b0;
    end
    if (!merged[ISC_BIT_D]) begin
      merged[ISC_BIT_Q] = 1'b0;
    end
    if (!merged[ISC_BIT_I] && !ISC_EXT_SUPPORTED[ISC_BIT_E]) begin
      merged[ISC_BIT_I] = 1'b1;
    end
    merged[ISC_BIT_E] = ~merged[ISC_BIT_I];
    wr.legal_ext = merged;
  end
endmodule
`default_nettype wire

// File: logic/isc_align_check.sv
// Decides whether a write must be dropped for instruction alignment
`timescale 1ns/1ps
`default_nettype none
module isc_align_check (
  isc_wr_if.align wr
);
  import isc_pkg::*;

  logic widen;

  // Losing compressed instructions raises alignment from 16 to 32 bits
  assign widen = wr.cur_ext[ISC_BIT_C] & ~wr.legal_ext[ISC_BIT_C];
  // Next instruction on an odd halfword cannot meet the new alignment
  assign wr.suppress = widen & wr.next_addr_b1;
endmodule
`default_nettype wire

// File: logic/isc_capability.sv
// Machine ISA capability register: width code, extension field, write rules
//
// What this block does
// - The register is always readable; this one is fully implemented, never zero.
// - Width code 1, 2, 3 mean 32, 64, 128-bit machine width.
// - The width code is read-only; writes never change it.
// - The register is as wide as the width its code names.
// - One presence bit per letter, A at bit 0 through Z at bit 25.
// - Integer-base bit 8 for full base, embedded-base bit 4 otherwise.
// - The extension field is write-any read-legal; some bits are writable.
// - Reset loads every supported extension, full base chosen over embedded.
// - A cleared extension bit disables that extension's instructions and registers.
// - Reserved extension bits always read zero.
// - User-mode bit 20 and supervisor-mode bit 18 show supported modes.
// - Bit 23 is set when any non-standard extension is present.
// - Bit 1 set guarantees the bit-manipulation subsets.
// - Embedded-base bit is read-only and reads as inverse of integer-base bit.
// - Enabling a feature while disabling its dependency disables both.
// - Constrained field combinations are replaced by a supported combination.
// - A write raising alignment with a misaligned next address is discarded.
// - Re-enabled extension state may hold arbitrary values.
// - Unsupported writes never fault; reads give a deterministic legal value.
`timescale 1ns/1ps
`default_nettype none
module isc_capability (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csr_wr_en,
  input wire logic [isc_pkg::ISC_WIDTH-1:0] csr_wr_data,
  input wire logic next_instr_addr_b1,
  output logic csr_ready,
  output logic [isc_pkg::ISC_WIDTH-1:0] csr_rd_data,
  output logic [isc_pkg::ISC_EXT_W-1:0] ext_enable,
  output logic [isc_pkg::ISC_EXT_W-1:0] ext_reenabled,
  output logic [1:0] native_width_code,
  output logic align_32,
  output logic wr_done,
  output logic wr_suppressed
);
  import isc_pkg::*;

  logic rst_meta_n;
  logic rst_sync_n;
  isc_state_t state;
  isc_state_t next_state;
  logic [ISC_EXT_W-1:0] ext_field;
  logic [ISC_EXT_W-1:0] wr_ext_q;
  logic addr_b1_q;
  logic [ISC_EXT_W-1:0] legal_q;
  logic suppress_q;
  logic commit;
  logic discard;
  logic take_wr;

  isc_wr_if wr_bus ();

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Legalisation of the written extension value
  isc_legalise u_legalise (
    .wr (wr_bus.legal)
  );

  // Alignment test against the next instruction address
  isc_align_check u_align (
    .wr (wr_bus.align)
  );

  // Feed helpers with the held register and the captured write
  assign wr_bus.cur_ext = ext_field;
  assign wr_bus.wr_ext = wr_ext_q;
  assign wr_bus.next_addr_b1 = addr_b1_q;

  // A write is taken only while the sequencer is idle
  assign take_wr = csr_wr_en && (state == ISC_IDLE);
  assign commit = (state == ISC_COMMIT) && !suppress_q;
  assign discard = (state == ISC_COMMIT) && suppress_q;

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ISC_IDLE: begin
        if (csr_wr_en) begin
          next_state = ISC_CHECK;
        end
      end
      ISC_CHECK: begin
        next_state = ISC_COMMIT;
      end
      ISC_COMMIT: begin
        next_state = ISC_IDLE;
      end
      default: begin
        next_state = ISC_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ISC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready while idle; a write offered when busy is ignored
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      csr_ready <= 1'b1;
    end else begin
      csr_ready <= (next_state == ISC_IDLE);
    end
  end

  // Capture the written extension bits; the width code bits are dropped
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ext_q <= ISC_EXT_RESET;
    end else if (take_wr) begin
      wr_ext_q <= csr_wr_data[ISC_EXT_W-1:0];
    end
  end

  // Capture the alignment of the following instruction with the write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_b1_q <= 1'b0;
    end else if (take_wr) begin
      addr_b1_q <= next_instr_addr_b1;
    end
  end

  // Hold the legal value and the suppress decision for the commit cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      legal_q <= ISC_EXT_RESET;
      suppress_q <= 1'b0;
    end else if (state == ISC_CHECK) begin
      legal_q <= wr_bus.legal_ext;
      suppress_q <= wr_bus.suppress;
    end
  end

  // Extension field: reset to full support, updated only by a kept write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_field <= ISC_EXT_RESET;
    end else if (commit) begin
      ext_field <= legal_q;
    end
  end

  // Read value: width code on top, zero padding, extension field below
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      csr_rd_data <= {ISC_NATIVE_WIDTH_CODE, {ISC_PAD_W{1'b0}}, ISC_EXT_RESET};
    end else if (commit) begin
      csr_rd_data <= {ISC_NATIVE_WIDTH_CODE, {ISC_PAD_W{1'b0}}, legal_q};
    end
  end

  // Width code output for width-dependent logic elsewhere in the hart
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      native_width_code <= ISC_NATIVE_WIDTH_CODE;
    end else begin
      native_width_code <= ISC_NATIVE_WIDTH_CODE;
    end
  end

  // Per-extension decode enables and re-enable pulses
  generate
    for (genvar i = 0; i < ISC_EXT_W; i++) begin : g_ext
      // Decode gates follow the held bit; a clear bit disables the extension
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          ext_enable[i] <= ISC_EXT_RESET[i];
        end else if (commit) begin
          ext_enable[i] <= legal_q[i];
        end
      end
      // One-cycle pulse when a disabled extension comes back
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          ext_reenabled[i] <= 1'b0;
        end else begin
          ext_reenabled[i] <= commit && legal_q[i] && !ext_field[i];
        end
      end
    end
  endgenerate

  // Alignment requirement: 32-bit once compressed instructions are off
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      align_32 <= ~ISC_EXT_RESET[ISC_BIT_C];
    end else if (commit) begin
      align_32 <= ~legal_q[ISC_BIT_C];
    end
  end

  // Completion pulse for a write that took effect
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= commit;
    end
  end

  // Pulse for a write dropped by the alignment check; no fault is raised
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_suppressed <= 1'b0;
    end else begin
      wr_suppressed <= discard;
    end
  end

  // Fixed bits: bit manipulation, modes and non-standard flag stay set
  // because they are supported but not writable; see the reset value.
  // Upper bits of the write data are never looked at.
  logic unused_upper;
  assign unused_upper = ^csr_wr_data[ISC_WIDTH-1:ISC_EXT_W];
endmodule
`default_nettype wire

// File: tb/isc_capability_props.sv
// Concurrent checks on the capability register ports
`timescale 1ns/1ps
`default_nettype none
module isc_capability_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csr_wr_en,
  input wire logic next_instr_addr_b1,
  input wire logic csr_ready,
  input wire logic [isc_pkg::ISC_WIDTH-1:0] csr_rd_data,
  input wire logic [isc_pkg::ISC_EXT_W-1:0] ext_enable,
  input wire logic [isc_pkg::ISC_EXT_W-1:0] ext_reenabled,
  input wire logic [1:0] native_width_code,
  input wire logic align_32,
  input wire logic wr_done,
  input wire logic wr_suppressed
);
  import isc_pkg::*;
  // One clock domain, raw reset disables every check
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_code_fixed: assert property (
    csr_rd_data[63:62] == ISC_NATIVE_WIDTH_CODE && native_width_code == ISC_NATIVE_WIDTH_CODE)
    else $error("width code moved");
  chk_reserved_zero: assert property (
    csr_rd_data[61:26] == '0 && (ext_enable & ~ISC_EXT_SUPPORTED) == '0)
    else $error("reserved bit set");
  chk_e_inverse: assert property (
    csr_rd_data[ISC_BIT_E] != csr_rd_data[ISC_BIT_I])
    else $error("embedded bit not inverse");
  chk_dep_clear: assert property (
    csr_rd_data[ISC_BIT_D] |-> csr_rd_data[ISC_BIT_F])
    else $error("double without single");
  chk_answer_time: assert property (
    csr_wr_en && csr_ready |-> ##1 !csr_ready ##1 !csr_ready ##1 (csr_ready && (wr_done ^ wr_suppressed)))
    else $error("write answer timing wrong");
  chk_idle_stable: assert property (
    !wr_done |-> $stable(ext_enable) && csr_rd_data[25:0] == ext_enable)
    else $error("field changed without write");
  chk_supp_cause: assert property (
    wr_suppressed |-> $past(next_instr_addr_b1, 3) && ext_enable[ISC_BIT_C] && $stable(csr_rd_data))
    else $error("bad suppression");
  chk_reenable_pulse: assert property (
    ext_reenabled == (ext_enable & ~$past(ext_enable)))
    else $error("reenable pulse wrong");
  chk_align_c: assert property (
    align_32 == !ext_enable[ISC_BIT_C])
    else $error("alignment flag wrong");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the capability register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isc_pkg::*;
  logic clk, rst_n, csr_wr_en, next_instr_addr_b1, csr_ready, align_32, wr_done, wr_suppressed;
  logic [63:0] csr_wr_data, csr_rd_data;
  logic [25:0] ext_enable, ext_reenabled, model;
  logic [1:0] native_width_code;
  int n_errors, samples_checked, cycles;
  integer seed = 32'h8DAE3B9F;
  isc_capability uut (.clk(clk), .rst_n(rst_n), .csr_wr_en(csr_wr_en),
    .csr_wr_data(csr_wr_data), .next_instr_addr_b1(next_instr_addr_b1),
    .csr_ready(csr_ready), .csr_rd_data(csr_rd_data), .ext_enable(ext_enable),
    .ext_reenabled(ext_reenabled), .native_width_code(native_width_code),
    .align_32(align_32), .wr_done(wr_done), .wr_suppressed(wr_suppressed));
  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected legal field after a write
  function automatic logic [25:0] legal(input logic [25:0] cur, input logic [25:0] wr);
    logic [25:0] m;
    m = ((wr & ISC_EXT_WRITABLE) | (cur & ~ISC_EXT_WRITABLE)) & ISC_EXT_SUPPORTED;
    if (!m[ISC_BIT_F]) m[ISC_BIT_D] = 1'b0;
    if (!m[ISC_BIT_D]) m[ISC_BIT_Q] = 1'b0;
    m[ISC_BIT_E] = ~m[ISC_BIT_I];
    return m;
  endfunction
  // One write, optionally with a refused request while busy
  task automatic write(input logic [63:0] d, input logic b1, input logic dup);
    logic [25:0] nxt;
    logic sup;
    int k;
    nxt = legal(model, d[25:0]);
    sup = model[ISC_BIT_C] && !nxt[ISC_BIT_C] && b1;
    csr_wr_en = 1'b1;
    csr_wr_data = d;
    next_instr_addr_b1 = b1;
    @(negedge clk);
    if (dup) begin
      csr_wr_data = ~d;
      next_instr_addr_b1 = ~b1;
      @(negedge clk);
    end
    csr_wr_en = 1'b0;
    k = 0;
    while (wr_done !== 1'b1 && wr_suppressed !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    check(k, dup ? 64'h1 : 64'h2);
    check(wr_suppressed, sup);
    check(wr_done, !sup);
    check(csr_ready, 1'b1);
    check(native_width_code, ISC_NATIVE_WIDTH_CODE);
    check(ext_reenabled, sup ? 26'h0 : nxt & ~model);
    if (!sup) model = nxt;
    check(csr_rd_data, {ISC_NATIVE_WIDTH_CODE, 36'h0, model});
    check(ext_enable, model);
    check(align_32, !model[ISC_BIT_C]);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    csr_wr_en = 1'b0;
    csr_wr_data = 64'h0;
    next_instr_addr_b1 = 1'b0;
    model = ISC_EXT_RESET;
    repeat (2) @(negedge clk);
    check(csr_rd_data, 64'h8000_0000_0095_112F);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    write(64'hFFFF_FFFF_FFFF_FFFF, 1'b0, 1'b0);
    write(64'h0000_0000_0000_0008, 1'b0, 1'b1);
    write(64'hFFFF_FFFF_FFFF_FFFF, 1'b1, 1'b0);
    write(64'h0000_0000_0000_0000, 1'b1, 1'b0);
    write(64'h0000_0000_0000_0004, 1'b1, 1'b0);
    for (int i = 0; i < 60; i++) begin
      write({$random(seed), $random(seed)}, 1'($random(seed)), 1'($random(seed)));
    end
    rst_n = 1'b0;
    #1;
    check(csr_rd_data, 64'h8000_0000_0095_112F);
    model = ISC_EXT_RESET;
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    write(64'h0000_0000_0000_0121, 1'b0, 1'b0);
    conclude();
  end
endmodule
bind isc_capability isc_capability_props chk (.clk(clk), .rst_n(rst_n),
  .csr_wr_en(csr_wr_en), .next_instr_addr_b1(next_instr_addr_b1), .csr_ready(csr_ready),
  .csr_rd_data(csr_rd_data), .ext_enable(ext_enable), .ext_reenabled(ext_reenabled),
  .native_width_code(native_width_code), .align_32(align_32), .wr_done(wr_done),
  .wr_suppressed(wr_suppressed));
`default_nettype wire
